// ### src/phy_ctl_defs.svh
`ifndef PHY_CTL_DEFS_SVH
`define PHY_CTL_DEFS_SVH

// Register indexes, byte address is four times the index
`define IDX_SELFID_CTRL      3'h4
`define IDX_IRQ_RST_CTRL     3'h5
`define ADDR_IDX_HI          4
`define ADDR_IDX_LO          2

// selfid_report_control fields
`define BIT_LINK_ACT_CTRL    7
`define BIT_CONTENDER        6
`define FLD_JITTER_HI        5
`define FLD_JITTER_LO        3
`define FLD_PWR_HI           2
`define FLD_PWR_LO           0
`define JITTER_VALUE         3'h0

// interrupt_and_reset_control fields
`define BIT_RESUME_IRQ_EN    7
`define BIT_SHORT_BR_REQ     6
`define BIT_CFG_TIMEOUT      5
`define BIT_CABLE_PWR_IRQ    4
`define BIT_STATE_TIMEOUT    3
`define BIT_PORT_EVENT_IRQ   2

// Reset values
`define RST_LINK_ACT_CTRL    1'h1
`define RST_CONTENDER        1'h0
`define RST_RESUME_IRQ_EN    1'h0
`define RST_SHORT_BR_REQ     1'h0
`define RST_CFG_TIMEOUT      1'h0
`define RST_CABLE_PWR_IRQ    1'h1
`define RST_STATE_TIMEOUT    1'h0
`define RST_PORT_EVENT_IRQ   1'h0

// Timing
`define CLK_PERIOD_NS        40
`define SHORT_RESET_NS       1300000
`define LONG_RESET_NS        166000
`define SHORT_RESET_CYCLES   ((`SHORT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LONG_RESET_CYCLES    ((`LONG_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W              16
`define NUM_PORTS            3

`endif

// ### src/phy_ctl_pkg.sv
package phy_ctl_pkg;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } avs_req_t;

   typedef struct packed {
      logic [2:0] power;
      logic       contender;
      logic       link_active;
   } selfid_bits_t;

   typedef enum logic [1:0] {
      BR_IDLE,
      BR_PENDING,
      BR_ACTIVE
   } brst_state_t;

endpackage

// ### src/sticky_flag.sv
`timescale 1ns/1ps
module sticky_flag #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_set,
   input  wire logic i_clear,
   output logic      o_flag
);

   // Set wins over a clear in the same cycle
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_flag <= RESET_VAL;
      end else if (i_set) begin
         o_flag <= 1'b1;
      end else if (i_clear) begin
         o_flag <= 1'b0;
      end
   end

endmodule

// ### src/reset_timer.sv
`timescale 1ns/1ps
`include "phy_ctl_defs.svh"
module reset_timer (
   input  wire logic                 i_clk,
   input  wire logic                 i_rst,
   input  wire logic                 i_start,
   input  wire logic [`TIMER_W-1:0]  i_cycles,
   output logic                      o_busy,
   output logic                      o_done
);

   logic [`TIMER_W-1:0] count;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         count  <= '0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else if (i_start) begin
         count  <= i_cycles - `TIMER_W'(1);
         o_busy <= 1'b1;
         o_done <= 1'b0;
      end else if (o_busy && count == '0) begin
         o_busy <= 1'b0;
         o_done <= 1'b1;
      end else begin
         count  <= o_busy ? count - `TIMER_W'(1) : count;
         o_done <= 1'b0;
      end
   end

endmodule

// ### src/phy_selfid_irq_control_bits.sv
`timescale 1ns/1ps
`include "phy_ctl_defs.svh"
module phy_selfid_irq_control_bits
   import phy_ctl_pkg::*;
#(
   parameter int SHORT_CYCLES = `SHORT_RESET_CYCLES,
   parameter int LONG_CYCLES  = `LONG_RESET_CYCLES
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   input  wire avs_req_t              i_avs,
   output logic [31:0]                o_avs_readdata,
   output logic                       o_avs_waitrequest,
   input  wire logic                  i_link_power_status,
   input  wire logic                  i_link_request,
   input  wire logic [2:0]            i_power_class_pins,
   input  wire logic                  i_cable_power_status,
   input  wire logic [`NUM_PORTS-1:0] i_resume_start,
   input  wire logic                  i_arb_tree_id_timeout,
   input  wire logic                  i_topology_has_1394a,
   input  wire logic                  i_legacy_1995_present,
   input  wire logic                  i_state_timeout,
   input  wire logic                  i_bus_reset,
   input  wire logic                  i_reset_opportunity,
   output selfid_bits_t               o_selfid,
   output logic                       o_link_if_operational,
   output logic                       o_link_request_served,
   output logic                       o_link_wake_out,
   output logic                       o_bus_reset_active,
   output logic                       o_bus_reset_short,
   output logic                       o_bus_reset_done
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic         link_active_report_ctrl;
   logic         contender_flag;
   logic [2:0]   node_power_class;
   logic         resume_watch_irq_enable;
   logic         short_bus_reset_request;
   logic         long_reset_pending;
   logic         config_timeout_flag;
   logic         cable_power_irq_flag;
   logic         state_timeout_flag;
   logic         port_event_irq_flag;
   logic         cable_power_prev;
   brst_state_t  brst_state;
   brst_state_t  next_brst_state;

   wire logic       req_any      = i_avs.read | i_avs.write;
   wire logic       bus_fire     = req_any & ~o_avs_waitrequest;
   wire logic [2:0] reg_idx      =
      i_avs.address[`ADDR_IDX_HI:`ADDR_IDX_LO];
   wire logic       lane0_wr     =
      i_avs.write & ~o_avs_waitrequest & i_avs.byteenable[0];
   wire logic       wr_selfid    = lane0_wr & (reg_idx == `IDX_SELFID_CTRL);
   wire logic       wr_irqrst    = lane0_wr & (reg_idx == `IDX_IRQ_RST_CTRL);
   wire logic [7:0] wdata        = i_avs.writedata[7:0];

   wire logic reset_wanted = short_bus_reset_request | long_reset_pending;
   wire logic reset_start =
      (brst_state == BR_PENDING) & i_reset_opportunity & reset_wanted;
   wire logic bus_reset_evt = i_bus_reset | reset_start;
   wire logic use_short =
      short_bus_reset_request & ~long_reset_pending & ~i_legacy_1995_present;
   wire logic [`TIMER_W-1:0] reset_cycles =
      use_short ? `TIMER_W'(SHORT_CYCLES) : `TIMER_W'(LONG_CYCLES);

   wire logic set_cfg_timeout =
      i_arb_tree_id_timeout & i_topology_has_1394a;
   wire logic set_cable_irq = cable_power_prev & ~i_cable_power_status;
   wire logic set_state_to  = i_state_timeout;
   wire logic set_port_event = resume_watch_irq_enable &
      ((|i_resume_start) |
       (~i_link_power_status &
        (set_cfg_timeout | set_cable_irq | set_state_to)));
   wire logic any_wake_flag =
      config_timeout_flag | cable_power_irq_flag | state_timeout_flag;
   wire logic next_wake =
      resume_watch_irq_enable & any_wake_flag & ~i_link_power_status;

   wire logic [7:0] selfid_rd = {link_active_report_ctrl, contender_flag,
                                 `JITTER_VALUE, node_power_class};
   wire logic [7:0] irqrst_rd = {resume_watch_irq_enable,
                                 short_bus_reset_request,
                                 config_timeout_flag, cable_power_irq_flag,
                                 state_timeout_flag, port_event_irq_flag,
                                 2'h0};
   wire logic [7:0] rd_sel =
      (reg_idx == `IDX_SELFID_CTRL)  ? selfid_rd :
      (reg_idx == `IDX_IRQ_RST_CTRL) ? irqrst_rd : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave, one wait cycle then answer

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= 32'h0000_0000;
      end else begin
         o_avs_waitrequest <= ~(req_any & o_avs_waitrequest);
         o_avs_readdata    <= {24'h00_0000, rd_sel};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Self-ID report control

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         link_active_report_ctrl <= `RST_LINK_ACT_CTRL;
         contender_flag          <= `RST_CONTENDER;
         node_power_class        <= i_power_class_pins;
      end else if (wr_selfid) begin
         link_active_report_ctrl <= wdata[`BIT_LINK_ACT_CTRL];
         contender_flag          <= wdata[`BIT_CONTENDER];
         node_power_class        <= wdata[`FLD_PWR_HI:`FLD_PWR_LO];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_selfid <= '0;
      end else begin
         o_selfid.link_active <= link_active_report_ctrl &
                                 i_link_power_status;
         o_selfid.contender   <= contender_flag;
         o_selfid.power       <= node_power_class;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link interface status and wake

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_link_if_operational <= 1'b0;
         o_link_request_served <= 1'b0;
         o_link_wake_out       <= 1'b0;
         cable_power_prev      <= 1'b1;
      end else begin
         o_link_if_operational <= i_link_power_status;
         o_link_request_served <= i_link_request &
                                  i_link_power_status;
         o_link_wake_out       <= next_wake;
         cable_power_prev      <= i_cable_power_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt enable and short reset request

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         resume_watch_irq_enable <= `RST_RESUME_IRQ_EN;
      end else if (wr_irqrst) begin
         resume_watch_irq_enable <= wdata[`BIT_RESUME_IRQ_EN];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         short_bus_reset_request <= `RST_SHORT_BR_REQ;
      end else if (wr_irqrst && wdata[`BIT_SHORT_BR_REQ]) begin
         short_bus_reset_request <= 1'b1;
      end else if (bus_reset_evt) begin
         short_bus_reset_request <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         long_reset_pending <= 1'b0;
      end else if (set_state_to) begin
         long_reset_pending <= 1'b1;
      end else if (reset_start) begin
         long_reset_pending <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky flags, cleared by writing 1

   sticky_flag #(.RESET_VAL(`RST_CFG_TIMEOUT)) u_cfg_timeout (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_set   (set_cfg_timeout),
      .i_clear (wr_irqrst & wdata[`BIT_CFG_TIMEOUT]),
      .o_flag  (config_timeout_flag)
   );

   sticky_flag #(.RESET_VAL(`RST_CABLE_PWR_IRQ)) u_cable_pwr (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_set   (set_cable_irq),
      .i_clear (wr_irqrst & wdata[`BIT_CABLE_PWR_IRQ]),
      .o_flag  (cable_power_irq_flag)
   );

   sticky_flag #(.RESET_VAL(`RST_STATE_TIMEOUT)) u_state_to (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_set   (set_state_to),
      .i_clear (wr_irqrst & wdata[`BIT_STATE_TIMEOUT]),
      .o_flag  (state_timeout_flag)
   );

   sticky_flag #(.RESET_VAL(`RST_PORT_EVENT_IRQ)) u_port_event (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_set   (set_port_event),
      .i_clear (wr_irqrst & wdata[`BIT_PORT_EVENT_IRQ]),
      .o_flag  (port_event_irq_flag)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bus reset sequencing

   always_comb begin
      next_brst_state = brst_state;
      unique case (brst_state)
         BR_IDLE: begin
            if (reset_wanted) begin
               next_brst_state = BR_PENDING;
            end
         end
         BR_PENDING: begin
            if (!reset_wanted) begin
               next_brst_state = BR_IDLE;
            end else if (i_reset_opportunity) begin
               next_brst_state = BR_ACTIVE;
            end
         end
         BR_ACTIVE: begin
            if (o_bus_reset_done) begin
               next_brst_state = BR_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         brst_state        <= BR_IDLE;
         o_bus_reset_short <= 1'b0;
      end else begin
         brst_state <= next_brst_state;
         if (reset_start) begin
            o_bus_reset_short <= use_short;
         end
      end
   end

   reset_timer u_reset_timer (
      .i_clk    (i_clk),
      .i_rst    (i_rst),
      .i_start  (reset_start),
      .i_cycles (reset_cycles),
      .o_busy   (o_bus_reset_active),
      .o_done   (o_bus_reset_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   link_active_bit_a: assert property (
      !$past(i_rst) |-> o_selfid.link_active ==
         $past(link_active_report_ctrl & i_link_power_status))
      else $error("self-ID link-active bit wrong");

   link_active_report_ctrl_keep_a: assert property (
      i_bus_reset && !wr_selfid |=> $stable(link_active_report_ctrl))
      else $error("link-active control changed without write");

   served_req_a: assert property (
      i_link_request && i_link_power_status && !link_active_report_ctrl
      |=> o_link_request_served)
      else $error("link request not served while link powered");

   contender_keep_a: assert property (
      !wr_selfid |=> $stable(contender_flag))
      else $error("contender flag changed without write");

   jitter_read_a: assert property (
      bus_fire && i_avs.read && reg_idx == `IDX_SELFID_CTRL
      |=> o_avs_readdata[`FLD_JITTER_HI:`FLD_JITTER_LO] == `JITTER_VALUE)
      else $error("jitter field not zero");

   resume_event_a: assert property (
      resume_watch_irq_enable && (|i_resume_start) |=> port_event_irq_flag)
      else $error("resume did not set port event flag");

   short_start_a: assert property (
      reset_start && use_short |=> o_bus_reset_active && o_bus_reset_short)
      else $error("short bus reset not started");

   short_clear_a: assert property (
      bus_reset_evt && !(wr_irqrst && wdata[`BIT_SHORT_BR_REQ])
      |=> !short_bus_reset_request)
      else $error("short reset request not cleared");

   legacy_long_a: assert property (
      reset_start && i_legacy_1995_present |=> !o_bus_reset_short)
      else $error("short reset used with legacy node");

   cfg_gate_a: assert property (
      !config_timeout_flag && !(i_arb_tree_id_timeout &&
                                i_topology_has_1394a)
      |=> !config_timeout_flag)
      else $error("config time-out raised without cause");

   wake_link_a: assert property (
      config_timeout_flag && resume_watch_irq_enable &&
      !i_link_power_status |=> o_link_wake_out)
      else $error("link wake not asserted");

   cable_edge_a: assert property (
      $fell(i_cable_power_status) |=> cable_power_irq_flag)
      else $error("cable power drop not flagged");

   bus_answer_a: assert property (
      req_any && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("bus answer late");

   short_done_c: cover property (
      o_bus_reset_short ##1 o_bus_reset_done);
   legacy_long_c: cover property (
      reset_start && i_legacy_1995_present && short_bus_reset_request);
   wake_c: cover property ($rose(o_link_wake_out));
   cfg_clear_c: cover property (
      config_timeout_flag ##1 !config_timeout_flag);

endmodule

// ### sim/link_layer_model.sv
`timescale 1ns/1ps
module link_layer_model (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_sleep,
   input  wire logic i_wake,
   output logic      o_link_power_status,
   output logic      o_link_request
);
   logic [2:0] wake_count;

   ////////////////////////////////////////////////////////////////////////////
   // Powers down on command, powers up a few cycles after a wake request
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_link_power_status <= 1'b1;
         wake_count          <= 3'h0;
      end else if (i_sleep) begin
         o_link_power_status <= 1'b0;
         wake_count          <= 3'h0;
      end else if (!o_link_power_status && i_wake) begin
         wake_count <= wake_count + 3'h1;
         if (wake_count == 3'h3) begin
            o_link_power_status <= 1'b1;
         end
      end
   end

   // Requests only while powered
   assign o_link_request = o_link_power_status;
endmodule

// ### sim/phy_selfid_irq_control_bits_bench.sv
`timescale 1ns/1ps
`include "phy_ctl_defs.svh"
module phy_selfid_irq_control_bits_bench
   import phy_ctl_pkg::*;
;
   localparam logic [4:0] SID = 5'h10;
   localparam logic [4:0] IRQ = 5'h14;
   avs_req_t              avs;
   logic [31:0]           rdata;
   logic [31:0]           rdata_q;
   logic                  clk, rst, wait_req, link_power, link_req, wake;
   logic                  sleep_req, cable_ok, arb_to, topo_a, legacy;
   logic                  state_to, bus_rst, opportunity;
   logic                  oper, served, br_active, br_short, br_done;
   logic [2:0]            pins;
   logic [`NUM_PORTS-1:0] resume;
   selfid_bits_t          selfid;
   int                    num_errors = 0;
   int                    samples_checked = 0;

   always #20 clk = ~clk;

   phy_selfid_irq_control_bits #(
      .SHORT_CYCLES(20),
      .LONG_CYCLES (8)
   ) dut (
      .i_clk                (clk),
      .i_rst                (rst),
      .i_avs                (avs),
      .o_avs_readdata       (rdata),
      .o_avs_waitrequest    (wait_req),
      .i_link_power_status  (link_power),
      .i_link_request       (link_req),
      .i_power_class_pins   (pins),
      .i_cable_power_status (cable_ok),
      .i_resume_start       (resume),
      .i_arb_tree_id_timeout(arb_to),
      .i_topology_has_1394a (topo_a),
      .i_legacy_1995_present(legacy),
      .i_state_timeout      (state_to),
      .i_bus_reset          (bus_rst),
      .i_reset_opportunity  (opportunity),
      .o_selfid             (selfid),
      .o_link_if_operational(oper),
      .o_link_request_served(served),
      .o_link_wake_out      (wake),
      .o_bus_reset_active   (br_active),
      .o_bus_reset_short    (br_short),
      .o_bus_reset_done     (br_done)
   );

   link_layer_model partner (
      .i_clk              (clk),
      .i_rst              (rst),
      .i_sleep            (sleep_req),
      .i_wake             (wake),
      .o_link_power_status(link_power),
      .o_link_request     (link_req)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checking and bus tasks
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task bus(input logic r, input logic [4:0] a, input logic [7:0] d,
            input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk);
      avs <= '{read: r, write: !r, address: a, byteenable: be,
               writedata: {24'h000000, d}};
      do begin
         @(posedge clk);
         n++;
      end while (wait_req !== 1'b0 && n < 50);
      rdata_q = rdata;
      avs <= '0;
      if (n >= 50) num_errors++;
   endtask

   task wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b0, a, d, 4'h1);
   endtask

   task rd(input logic [4:0] a, input logic [7:0] exp);
      bus(1'b1, a, 8'h00, 4'h1);
      check(rdata_q, {24'h000000, exp});
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Length and kind of the next bus reset, and its closing pulse
   task measure(input logic exp_short, input int exp_len);
      int   n;
      int   w;
      logic done_seen;
      n = 0;
      w = 0;
      done_seen = 1'b0;
      while (br_active !== 1'b1 && w < 100) begin
         @(posedge clk);
         w++;
      end
      check({31'h0, br_short}, {31'h0, exp_short});
      while (br_active === 1'b1 && n < 100) begin
         done_seen |= br_done;
         @(posedge clk);
         n++;
      end
      done_seen |= br_done;
      @(posedge clk);
      done_seen |= br_done;
      check(n, exp_len);
      check({31'h0, done_seen}, 32'h00000001);
   endtask

   task end_of_test;
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #200000;
      num_errors++;
      end_of_test;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      avs = '0;
      {sleep_req, arb_to, topo_a, legacy, state_to, bus_rst} = 6'h00;
      cable_ok = 1'b1;
      opportunity = 1'b0;
      resume = '0;
      pins = 3'h5;
      tick(6);
      rst <= 1'b0;
      rd(SID, 8'h85);
      rd(IRQ, 8'h10);
      check(32'(selfid), 32'h00000015);
      wr(SID, 8'h7A);
      rd(SID, 8'h42);
      check(32'(selfid), 32'h0000000A);
      check({31'h0, oper}, 32'h00000001);
      check({31'h0, served}, 32'h00000001);
      wr(SID, 8'hC2);
      tick(2);
      check(32'(selfid), 32'h0000000B);
      bus(1'b0, SID, 8'h00, 4'h0);
      rd(SID, 8'hC2);
      wr(5'h18, 8'hFF);
      rd(5'h18, 8'h00);
      wr(IRQ, 8'h90);
      rd(IRQ, 8'h80);
      pins <= 3'h1;
      @(posedge clk) bus_rst <= 1'b1;
      @(posedge clk) bus_rst <= 1'b0;
      rd(SID, 8'hC2);
      rd(IRQ, 8'h80);
      @(posedge clk) arb_to <= 1'b1;
      @(posedge clk) arb_to <= 1'b0;
      rd(IRQ, 8'h80);
      topo_a <= 1'b1;
      @(posedge clk) arb_to <= 1'b1;
      @(posedge clk) arb_to <= 1'b0;
      rd(IRQ, 8'hA0);
      check({31'h0, wake}, 32'h00000000);
      @(posedge clk) sleep_req <= 1'b1;
      @(posedge clk) sleep_req <= 1'b0;
      for (int k = 0; k < 20 && wake !== 1'b1; k++) @(posedge clk);
      check({31'h0, wake}, 32'h00000001);
      check({30'h0, oper, served}, 32'h00000000);
      check(32'(selfid), 32'h0000000A);
      for (int k = 0; k < 20 && link_power !== 1'b1; k++) @(posedge clk);
      tick(2);
      check({31'h0, wake}, 32'h00000000);
      wr(IRQ, 8'hA0);
      rd(IRQ, 8'h80);
      @(posedge clk) sleep_req <= 1'b1;
      @(posedge clk) sleep_req <= 1'b0;
      tick(3);
      check({31'h0, wake}, 32'h00000000);
      @(posedge clk) cable_ok <= 1'b0;
      @(posedge clk) cable_ok <= 1'b1;
      rd(IRQ, 8'h94);
      wr(IRQ, 8'h84);
      rd(IRQ, 8'h90);
      wr(IRQ, 8'h90);
      tick(10);
      @(posedge clk) resume <= 3'h4;
      @(posedge clk) resume <= 3'h0;
      rd(IRQ, 8'h84);
      wr(IRQ, 8'h04);
      @(posedge clk) resume <= 3'h1;
      @(posedge clk) resume <= 3'h0;
      rd(IRQ, 8'h00);
      wr(IRQ, 8'h40);
      tick(5);
      check({31'h0, br_active}, 32'h00000000);
      rd(IRQ, 8'h40);
      opportunity <= 1'b1;
      measure(1'b1, 20);
      rd(IRQ, 8'h00);
      legacy <= 1'b1;
      wr(IRQ, 8'h40);
      measure(1'b0, 8);
      opportunity <= 1'b0;
      legacy <= 1'b0;
      wr(IRQ, 8'h40);
      @(posedge clk) bus_rst <= 1'b1;
      @(posedge clk) bus_rst <= 1'b0;
      rd(IRQ, 8'h00);
      opportunity <= 1'b1;
      tick(3);
      check({31'h0, br_active}, 32'h00000000);
      tick(57);
      @(posedge clk) state_to <= 1'b1;
      @(posedge clk) state_to <= 1'b0;
      measure(1'b0, 8);
      rd(IRQ, 8'h08);
      wr(IRQ, 8'h08);
      rd(IRQ, 8'h00);
      end_of_test;
   end
endmodule
